// [shared/dfa_pkg.sv]
// dfa_pkg: shared constants and types for the drive fault annunciator
// assumes a single 20 MHz clock domain with synchronous active-high reset
package dfa_pkg;
	localparam int CODE_W = 16;
	localparam int SEL_W = 8;
	localparam int NTERM = 3;
	localparam int REG_AW = 4;
	// output terminal function codes
	localparam logic [SEL_W-1:0] FUNC_FAULT = 8'h0E;
	localparam logic [SEL_W-1:0] FUNC_ALARM = 8'h10;
	// register offsets
	localparam logic [REG_AW-1:0] OFF_CTRL = 4'h0;
	localparam logic [REG_AW-1:0] OFF_STAT = 4'h1;
	localparam logic [REG_AW-1:0] OFF_IRQ_STAT = 4'h2;
	localparam logic [REG_AW-1:0] OFF_IRQ_MASK = 4'h3;
	localparam logic [REG_AW-1:0] OFF_TSEL0 = 4'h4;
	localparam logic [REG_AW-1:0] OFF_TSEL1 = 4'h5;
	localparam logic [REG_AW-1:0] OFF_TSEL2 = 4'h6;
	localparam logic [REG_AW-1:0] OFF_STOPSEL = 4'h7;
	localparam logic [REG_AW-1:0] OFF_CODE = 4'h8;
	// ctrl bits
	localparam int CTRL_FRESET_BIT = 0;
	// interrupt status bits
	localparam int IRQ_FAULT_BIT = 0;
	localparam int IRQ_ALARM_BIT = 1;
	localparam int IRQ_OPER_BIT = 2;
	localparam int IRQ_TUNE_BIT = 3;
	localparam int IRQ_COPY_BIT = 4;
	localparam int IRQ_W = 5;
	// reset values
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;
	localparam logic [SEL_W-1:0] TSEL_RST = 8'hFF;
	localparam logic [1:0] STOPSEL_RST = 2'h0;
	// lamp flash half period: 250 ms
	localparam int FLASH_HALF_MS = 250;
	localparam int CLK_HZ = 20_000_000;
	localparam int FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;
	// stopping methods
	typedef enum logic [1:0] {DFA_STOP_COAST, DFA_STOP_RAMP, DFA_STOP_FAST, DFA_STOP_RUN} dfa_stop_t;
	typedef enum logic [2:0] {DFA_CAT_NONE, DFA_CAT_FAULT, DFA_CAT_ALARM, DFA_CAT_OPER, DFA_CAT_TUNE,
		DFA_CAT_COPY} dfa_cat_t;
endpackage

// [hdl/dfa_flasher.sv]
// dfa_flasher: square wave for the flashing lamp state
// assumes the single system clock; count is a parameter so simulation can shorten it
`timescale 1ns/10ps
module dfa_flasher import dfa_pkg::*; #(
	parameter int HALF_CYC = FLASH_HALF_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	output logic blink
);
	logic [31:0] cnt_r;
	logic blink_r;
	wire wrap = (cnt_r == 32'(HALF_CYC - 1));
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_r <= 32'h0;
			blink_r <= 1'b0;
		end else begin
			cnt_r <= wrap ? 32'h0 : cnt_r + 32'h1;
			if (wrap) begin
				blink_r <= ~blink_r;
			end
		end
	end
	assign blink = blink_r;
endmodule // dfa_flasher

// [hdl/dfa_sync.sv]
// dfa_sync: two-flop synchroniser for a bundle of pin levels
// assumes inputs are asynchronous to mclk; only the second stage is read
`timescale 1ns/10ps
module dfa_sync #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	always_ff @(posedge mclk) begin
		if (rst) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
		end
	end
	assign q = s2_r;
endmodule // dfa_sync

// [hdl/dfa_annunciator.sv]
// dfa_annunciator: fault and alarm classification, lamp, code display, motor inhibit, terminals
// assumes detection inputs are pin levels (synchronised here) and a plain register port
`timescale 1ns/10ps
// What this block does
// - On a fault the fault code is shown and the lamp is lit steadily.
// - On a fault the motor output is cut so the motor coasts unless another stop applies.
// - Faults flagged as selectable use the configured stopping method instead of coasting.
// - Any terminal whose function select is the fault function is driven while a fault is active.
// - A fault latches and blocks running until a fault reset arrives with the condition gone.
// - On a minor fault or alarm the alarm code is shown and the lamp flashes.
// - During a minor fault or alarm the motor keeps running unless a configured stop applies.
// - On a minor fault any terminal selected for the alarm function is driven.
// - With no terminal selected for the alarm function, terminals are untouched by minor faults.
// - A condition classed as an alarm never drives the minor-fault output.
// - Minor faults and alarms clear by themselves with no fault reset.
// - Bad setting combinations raise an operation error that blocks running until corrected.
// - Operation, tuning and copy errors show their code but drive no terminal alarm.
// - An error during auto-tuning stops the motor by coasting.
// - A failed keypad backup, restore or verify raises a copy error.
// - A copy error stays shown until any keypad key is pressed.
module dfa_annunciator import dfa_pkg::*; #(
	parameter int FLASH_CYC = FLASH_HALF_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic fault_det,
	input wire logic [CODE_W-1:0] fault_code,
	input wire logic fault_stop_sel_en,
	input wire logic minor_det,
	input wire logic alarm_det,
	input wire logic [CODE_W-1:0] alarm_code,
	input wire logic alarm_stop_sel_en,
	input wire logic setting_bad,
	input wire logic [CODE_W-1:0] oper_code,
	input wire logic tune_err,
	input wire logic [CODE_W-1:0] tune_code,
	input wire logic copy_fail,
	input wire logic [CODE_W-1:0] copy_code,
	input wire logic key_press,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [REG_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic [CODE_W-1:0] display_code,
	output logic fault_indicator_lamp,
	output logic motor_output_en,
	output logic [1:0] stop_method,
	output logic run_inhibit,
	output logic minor_fault_out,
	output logic [NTERM-1:0] multi_function_digital_output,
	output logic irq
);
	// pin-side detection levels pass the synchroniser before use
	localparam int SW = 9;
	logic [SW-1:0] raw_s;
	logic [SW-1:0] syn;
	assign raw_s = {fault_det, fault_stop_sel_en, minor_det, alarm_det, alarm_stop_sel_en,
		setting_bad, tune_err, copy_fail, key_press};
	dfa_sync #(.W(SW)) u_sync (
		.mclk(mclk),
		.rst(rst),
		.d(raw_s),
		.q(syn)
	);
	wire f_det = syn[8];
	wire f_sel = syn[7];
	wire m_det = syn[6];
	wire a_det = syn[5];
	wire a_sel = syn[4];
	wire op_bad = syn[3];
	wire tn_err = syn[2];
	wire cp_fail = syn[1];
	wire key_s = syn[0];
	// codes take the same two-flop path as their flags so a code lines up with its flag
	localparam int CSW = 5 * CODE_W;
	logic [CSW-1:0] codes_raw;
	logic [CSW-1:0] codes_s;
	assign codes_raw = {fault_code, alarm_code, oper_code, tune_code, copy_code};
	dfa_sync #(.W(CSW)) u_code_sync (
		.mclk(mclk),
		.rst(rst),
		.d(codes_raw),
		.q(codes_s)
	);
	wire [CODE_W-1:0] fault_code_s = codes_s[4*CODE_W +: CODE_W];
	wire [CODE_W-1:0] alarm_code_s = codes_s[3*CODE_W +: CODE_W];
	wire [CODE_W-1:0] oper_code_s = codes_s[2*CODE_W +: CODE_W];
	wire [CODE_W-1:0] tune_code_s = codes_s[CODE_W +: CODE_W];
	wire [CODE_W-1:0] copy_code_s = codes_s[0 +: CODE_W];

	logic blink;
	dfa_flasher #(.HALF_CYC(FLASH_CYC)) u_flash (
		.mclk(mclk),
		.rst(rst),
		.blink(blink)
	);

	// software registers
	logic [SEL_W-1:0] tsel_r [NTERM];
	logic [1:0] stopsel_r;
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_mask_r;
	logic [31:0] rdata_r;

	// latched state
	logic fault_r;
	logic [CODE_W-1:0] fault_code_r;
	logic fault_sel_r;
	logic copy_r;
	logic [CODE_W-1:0] copy_code_r;
	logic key_d_r;
	logic tune_r;
	logic [CODE_W-1:0] disp_r;
	logic lamp_r;
	logic motor_en_r;
	logic [1:0] stop_r;
	logic inhibit_r;
	logic minor_r;
	logic [NTERM-1:0] term_r;
	logic f_prev_r;
	logic a_prev_r;
	logic op_prev_r;
	logic tn_prev_r;

	wire wr_ctrl = reg_wr && (reg_addr == OFF_CTRL);
	wire fault_reset = wr_ctrl && reg_wdata[CTRL_FRESET_BIT];
	wire key_rise = key_s && !key_d_r;
	wire alarm_any = m_det || a_det;

	// latch until reset and clear condition
	wire fault_nxt_v = f_det ? 1'b1 : ((fault_reset && !f_det) ? 1'b0 : fault_r);
	// any key press clears; a new failure wins
	wire copy_nxt_v = cp_fail ? 1'b1 : (key_rise ? 1'b0 : copy_r);
	wire tune_nxt_v = tn_err;

	function automatic logic term_hit(input logic [SEL_W-1:0] sel, input logic [SEL_W-1:0] func);
		term_hit = (sel == func);
	endfunction

	logic [NTERM-1:0] term_nxt;
	always_comb begin
		term_nxt = term_r;
		for (int i = 0; i < NTERM; i++) begin
			if (term_hit(tsel_r[i], FUNC_FAULT)) begin
				term_nxt[i] = fault_nxt_v;
			// alarm terminal on minor fault only
			// plain alarms do not drive it
			end else if (term_hit(tsel_r[i], FUNC_ALARM)) begin
				term_nxt[i] = m_det;
			end else begin
				term_nxt[i] = 1'b0;
			end
		end
	end

	// display and lamp priority
	logic [CODE_W-1:0] disp_nxt;
	logic lamp_nxt;
	always_comb begin
		disp_nxt = '0;
		lamp_nxt = 1'b0;
		if (fault_nxt_v) begin
			disp_nxt = f_det ? fault_code_s : fault_code_r;
			lamp_nxt = 1'b1;
		end else if (alarm_any) begin
			disp_nxt = alarm_code_s;
			lamp_nxt = blink;
		end else if (tune_nxt_v) begin
			disp_nxt = tune_code_s;
			lamp_nxt = blink;
		end else if (op_bad) begin
			disp_nxt = oper_code_s;
			lamp_nxt = blink;
		end else if (copy_nxt_v) begin
			disp_nxt = cp_fail ? copy_code_s : copy_code_r;
		end
	end

	// motor drive and stopping method
	logic motor_nxt;
	logic [1:0] stop_nxt;
	logic inhibit_nxt;
	always_comb begin
		motor_nxt = 1'b1;
		stop_nxt = DFA_STOP_RUN;
		if (fault_nxt_v) begin
			motor_nxt = 1'b0;
			stop_nxt = DFA_STOP_COAST;
			if (fault_sel_r || (f_det && f_sel)) begin
				stop_nxt = stopsel_r;
			end
		end else if (tune_nxt_v) begin
			motor_nxt = 1'b0;
			stop_nxt = DFA_STOP_COAST;
		end else if (alarm_any && a_sel) begin
			motor_nxt = 1'b0;
			stop_nxt = stopsel_r;
		end
		inhibit_nxt = fault_nxt_v || op_bad;
		if (inhibit_nxt) begin
			motor_nxt = 1'b0;
		end
	end

	// event flags for interrupts; set wins over clear
	logic [IRQ_W-1:0] ev;
	assign ev = {cp_fail && !copy_r, tn_err && !tn_prev_r, op_bad && !op_prev_r,
		alarm_any && !a_prev_r, f_det && !f_prev_r};
	wire wr_istat = reg_wr && (reg_addr == OFF_IRQ_STAT);

	always_ff @(posedge mclk) begin
		if (rst) begin
			fault_r <= 1'b0;
			fault_code_r <= '0;
			fault_sel_r <= 1'b0;
			copy_r <= 1'b0;
			copy_code_r <= '0;
			key_d_r <= 1'b0;
			tune_r <= 1'b0;
			f_prev_r <= 1'b0;
			a_prev_r <= 1'b0;
			op_prev_r <= 1'b0;
			tn_prev_r <= 1'b0;
		end else begin
			fault_r <= fault_nxt_v;
			if (f_det && !fault_r) begin
				fault_code_r <= fault_code_s;
				fault_sel_r <= f_sel;
			end else if (!fault_nxt_v) begin
				fault_sel_r <= 1'b0;
			end
			copy_r <= copy_nxt_v;
			if (cp_fail) begin
				copy_code_r <= copy_code_s;
			end
			key_d_r <= key_s;
			tune_r <= tune_nxt_v;
			f_prev_r <= f_det;
			a_prev_r <= alarm_any;
			op_prev_r <= op_bad;
			tn_prev_r <= tn_err;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			disp_r <= '0;
			lamp_r <= 1'b0;
			motor_en_r <= 1'b0;
			stop_r <= DFA_STOP_COAST;
			inhibit_r <= 1'b0;
			minor_r <= 1'b0;
			term_r <= '0;
		end else begin
			disp_r <= disp_nxt;
			lamp_r <= lamp_nxt;
			motor_en_r <= motor_nxt;
			stop_r <= stop_nxt;
			inhibit_r <= inhibit_nxt;
			minor_r <= m_det;
			term_r <= term_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < NTERM; i++) begin
				tsel_r[i] <= TSEL_RST;
			end
			stopsel_r <= STOPSEL_RST;
			irq_mask_r <= IRQ_MASK_RST;
			irq_stat_r <= '0;
		end else begin
			if (reg_wr && reg_addr == OFF_TSEL0) begin
				tsel_r[0] <= reg_wdata[SEL_W-1:0];
			end
			if (reg_wr && reg_addr == OFF_TSEL1) begin
				tsel_r[1] <= reg_wdata[SEL_W-1:0];
			end
			if (reg_wr && reg_addr == OFF_TSEL2) begin
				tsel_r[2] <= reg_wdata[SEL_W-1:0];
			end
			if (reg_wr && reg_addr == OFF_STOPSEL) begin
				stopsel_r <= reg_wdata[1:0];
			end
			if (reg_wr && reg_addr == OFF_IRQ_MASK) begin
				irq_mask_r <= reg_wdata[IRQ_W-1:0];
			end
			irq_stat_r <= (irq_stat_r & ~(wr_istat ? reg_wdata[IRQ_W-1:0] : '0)) | ev;
		end
	end

	// read mux; unmapped offsets read zero
	logic [31:0] rd_mux;
	always_comb begin
		case (reg_addr)
			OFF_STAT: rd_mux = {24'h0, minor_r, inhibit_r, motor_en_r, lamp_r, tune_r, copy_r, op_bad,
				fault_r};
			OFF_IRQ_STAT: rd_mux = {27'h0, irq_stat_r};
			OFF_IRQ_MASK: rd_mux = {27'h0, irq_mask_r};
			OFF_TSEL0: rd_mux = {24'h0, tsel_r[0]};
			OFF_TSEL1: rd_mux = {24'h0, tsel_r[1]};
			OFF_TSEL2: rd_mux = {24'h0, tsel_r[2]};
			OFF_STOPSEL: rd_mux = {30'h0, stopsel_r};
			OFF_CODE: rd_mux = {16'h0, disp_r};
			default: rd_mux = 32'h0;
		endcase
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_r <= 32'h0;
		end else begin
			rdata_r <= reg_rd ? rd_mux : 32'h0;
		end
	end

	assign reg_rdata = rdata_r;
	assign display_code = disp_r;
	assign fault_indicator_lamp = lamp_r;
	assign motor_output_en = motor_en_r;
	assign stop_method = stop_r;
	assign run_inhibit = inhibit_r;
	assign minor_fault_out = minor_r;
	assign multi_function_digital_output = term_r;
	// level interrupt while any unmasked bit stands
	assign irq = |(irq_stat_r & irq_mask_r);
endmodule // dfa_annunciator

// [test/dfa_checker.sv]
// dfa_checker: port timing relations of the annunciator
// assumes bind onto dfa_annunciator, flash count shortened in sim
`timescale 1ns/10ps
module dfa_checker import dfa_pkg::*; #(
	parameter int FLASH_CYC = 2
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic fault_det,
	input wire logic [CODE_W-1:0] fault_code,
	input wire logic minor_det,
	input wire logic alarm_det,
	input wire logic [CODE_W-1:0] alarm_code,
	input wire logic tune_err,
	input wire logic [CODE_W-1:0] display_code,
	input wire logic fault_indicator_lamp,
	input wire logic motor_output_en,
	input wire logic [1:0] stop_method,
	input wire logic run_inhibit,
	input wire logic minor_fault_out,
	input wire logic [NTERM-1:0] multi_function_digital_output
);
	logic [7:0] hold_r;
	logic calm;
	assign calm = !fault_det && !run_inhibit;
	// lamp stable run length; saturates so a long dark spell cannot wrap
	always_ff @(posedge mclk) begin
		if (rst || $changed(fault_indicator_lamp)) begin
			hold_r <= 8'h00;
		end else if (hold_r != 8'hFF) begin
			hold_r <= hold_r + 8'h01;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_fault_steady: assert property (
		fault_det[*4] |-> fault_indicator_lamp && display_code == fault_code) else $error("fault lamp or code");
	a_fault_motor_cut: assert property (
		fault_det[*4] |-> !motor_output_en && run_inhibit) else $error("fault left motor on");
	a_fault_latch: assert property (
		fault_det[*4] ##1 !fault_det |-> run_inhibit[*4]) else $error("fault did not latch");
	a_term_cause: assert property (
		|multi_function_digital_output |-> run_inhibit || minor_fault_out) else $error("terminal without cause");
	a_alarm_code: assert property (
		(alarm_det && calm)[*4] |-> display_code == alarm_code) else $error("alarm code missing");
	a_alarm_flash: assert property (
		(alarm_det && calm)[*8] |-> hold_r <= FLASH_CYC + 1) else $error("lamp not flashing");
	a_minor_out_on: assert property (
		minor_det[*4] |-> minor_fault_out) else $error("minor output missing");
	a_minor_out_off: assert property (
		(!minor_det)[*4] |-> !minor_fault_out) else $error("minor output stuck");
	a_tune_coast: assert property (
		(tune_err && !fault_det && !alarm_det && !minor_det)[*4] |-> !motor_output_en && stop_method == DFA_STOP_COAST)
		else $error("tuning error did not coast");
endmodule // dfa_checker
bind dfa_annunciator dfa_checker #(.FLASH_CYC(FLASH_CYC)) dfa_checker_i (.mclk(mclk), .rst(rst),
	.fault_det(fault_det), .fault_code(fault_code), .minor_det(minor_det), .alarm_det(alarm_det),
	.alarm_code(alarm_code), .tune_err(tune_err), .display_code(display_code),
	.fault_indicator_lamp(fault_indicator_lamp), .motor_output_en(motor_output_en), .stop_method(stop_method),
	.run_inhibit(run_inhibit), .minor_fault_out(minor_fault_out),
	.multi_function_digital_output(multi_function_digital_output));

// [test/dfa_keypad_model.sv]
// dfa_keypad_model: operator keys and copy operation outcome
// assumes the bench commands it by one-cycle pulses
`timescale 1ns/10ps
module dfa_keypad_model (
	input wire logic mclk,
	input wire logic fail_cmd,
	input wire logic key_cmd,
	output logic copy_fail,
	output logic key_press
);
	logic [2:0] fail_r = 3'h0;
	logic [2:0] key_r = 3'h0;
	// levels held three cycles, long enough to pass the pin synchroniser
	always @(posedge mclk) begin
		fail_r <= fail_cmd ? 3'h7 : fail_r >> 1;
		key_r <= key_cmd ? 3'h7 : key_r >> 1;
	end
	assign copy_fail = fail_r[0];
	assign key_press = key_r[0];
endmodule // dfa_keypad_model

// [test/dfa_annunciator_tb_top.sv]
// dfa_annunciator_tb_top: self-checking bench for the annunciator
// assumes the keypad model and checker in test/, flash count cut to 2
`timescale 1ns/10ps
module dfa_annunciator_tb_top import dfa_pkg::*;;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic fault_det, fault_stop_sel_en, minor_det, alarm_det, alarm_stop_sel_en, setting_bad, tune_err;
	logic key_cmd, fail_cmd, copy_fail, key_press, reg_wr, reg_rd, lamp, motor, run_inhibit, minor_out, irq;
	logic [CODE_W-1:0] fault_code, alarm_code, oper_code, tune_code, copy_code, disp;
	logic [REG_AW-1:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd_v;
	logic [1:0] stop_method;
	logic [NTERM-1:0] dout;
	int n_errors = 0;
	int checks = 0;
	int cyc = 0;
	dfa_annunciator #(.FLASH_CYC(2)) dfa_annunciator_i (.mclk(mclk), .rst(rst), .fault_det(fault_det),
		.fault_code(fault_code), .fault_stop_sel_en(fault_stop_sel_en), .minor_det(minor_det),
		.alarm_det(alarm_det), .alarm_code(alarm_code), .alarm_stop_sel_en(alarm_stop_sel_en),
		.setting_bad(setting_bad), .oper_code(oper_code), .tune_err(tune_err), .tune_code(tune_code),
		.copy_fail(copy_fail), .copy_code(copy_code), .key_press(key_press), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .display_code(disp),
		.fault_indicator_lamp(lamp), .motor_output_en(motor), .stop_method(stop_method),
		.run_inhibit(run_inhibit), .minor_fault_out(minor_out), .multi_function_digital_output(dout), .irq(irq));
	dfa_keypad_model dfa_keypad_model_i (.mclk(mclk), .fail_cmd(fail_cmd), .key_cmd(key_cmd),
		.copy_fail(copy_fail), .key_press(key_press));
	always #25 mclk = ~mclk;
	task end_of_test;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// a hang cuts the run short well past the expected 135 or so cycles
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_errors++;
			end_of_test();
		end
	end
	task chk(input logic [31:0] v, input logic [31:0] e);
		checks++;
		if (v !== e) begin
			n_errors++;
			$display("MISMATCH %0t seen %h want %h", $time, v, e);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [REG_AW-1:0] a);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 rd_v = reg_rdata;
	endtask
	task t_regs;
		rd(OFF_TSEL0);
		chk(rd_v, {24'h0, TSEL_RST});
		rd(OFF_IRQ_MASK);
		chk(rd_v, {27'h0, IRQ_MASK_RST});
		rd(4'hF);
		chk(rd_v, 32'h0);
		wr(OFF_TSEL0, {24'h0, FUNC_FAULT});
		wr(OFF_TSEL1, {24'h0, FUNC_ALARM});
		wr(OFF_TSEL2, 32'h0);
		wr(OFF_STOPSEL, 32'h2);
		wr(OFF_IRQ_MASK, 32'h1);
		$display("done: registers");
	endtask
	task t_fault;
		@(posedge mclk);
		fault_det <= 1'b1;
		fault_stop_sel_en <= 1'b1;
		alarm_det <= 1'b1;
		wt(5);
		chk(disp, fault_code);
		chk(motor, 1'b0);
		chk(stop_method, DFA_STOP_FAST);
		chk(dout, 3'h1);
		chk(irq, 1'b1);
		wt(6);
		chk(lamp, 1'b1);
		wt(2);
		chk(lamp, 1'b1);
		wr(OFF_CTRL, 32'h1);
		fault_det <= 1'b0;
		alarm_det <= 1'b0;
		wt(6);
		chk(run_inhibit, 1'b1);
		wr(OFF_CTRL, 32'h1);
		fault_stop_sel_en <= 1'b0;
		wt(2);
		chk(run_inhibit, 1'b0);
		chk(dout, 3'h0);
		fault_det <= 1'b1;
		wt(5);
		chk(stop_method, DFA_STOP_COAST);
		chk(dout, 3'h1);
		fault_det <= 1'b0;
		wt(3);
		wr(OFF_CTRL, 32'h1);
		wt(2);
		chk(run_inhibit, 1'b0);
		rd(OFF_IRQ_STAT);
		chk(rd_v[IRQ_FAULT_BIT], 1'b1);
		wr(OFF_IRQ_STAT, 32'h1F);
		wt(1);
		chk(irq, 1'b0);
		$display("done: fault");
	endtask
	task t_minor;
		@(posedge mclk);
		minor_det <= 1'b1;
		wt(5);
		chk(dout, 3'h2);
		chk(motor, 1'b1);
		chk(disp, alarm_code);
		chk(irq, 1'b0);
		minor_det <= 1'b0;
		alarm_det <= 1'b1;
		wt(5);
		chk(minor_out, 1'b0);
		chk(dout, 3'h0);
		alarm_stop_sel_en <= 1'b1;
		wt(5);
		chk(stop_method, DFA_STOP_FAST);
		alarm_det <= 1'b0;
		alarm_stop_sel_en <= 1'b0;
		wr(OFF_TSEL1, 32'h0);
		minor_det <= 1'b1;
		wt(5);
		chk(dout, 3'h0);
		minor_det <= 1'b0;
		$display("done: minor");
	endtask
	task t_errors;
		wr(OFF_TSEL1, {24'h0, FUNC_ALARM});
		setting_bad <= 1'b1;
		wt(5);
		chk(run_inhibit, 1'b1);
		chk(disp, oper_code);
		chk(dout, 3'h0);
		setting_bad <= 1'b0;
		tune_err <= 1'b1;
		wt(5);
		chk(run_inhibit, 1'b0);
		chk(motor, 1'b0);
		chk(disp, tune_code);
		chk(dout, 3'h0);
		tune_err <= 1'b0;
		fail_cmd <= 1'b1;
		@(posedge mclk);
		fail_cmd <= 1'b0;
		wt(20);
		chk(disp, copy_code);
		chk(dout, 3'h0);
		key_cmd <= 1'b1;
		@(posedge mclk);
		key_cmd <= 1'b0;
		wt(6);
		chk(disp, 16'h0000);
		$display("done: errors");
	endtask
	initial begin
		{fault_det, fault_stop_sel_en, minor_det, alarm_det, alarm_stop_sel_en} = 5'h00;
		{setting_bad, tune_err, key_cmd, fail_cmd, reg_wr, reg_rd} = 6'h00;
		{fault_code, alarm_code, oper_code} = {16'h0042, 16'h0085, 16'h0301};
		{tune_code, copy_code, reg_addr, reg_wdata} = {16'h0E01, 16'hC0E1, 4'h0, 32'h0};
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		wt(3);
		t_regs();
		t_fault();
		t_minor();
		t_errors();
		end_of_test();
	end
endmodule // dfa_annunciator_tb_top
